// *** hdl/reset_ctrl_pkg.sv ***
package reset_ctrl_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_PERIPH_RST = 8'h0C;
    localparam logic [7:0] ADDR_APP_INT_RST = 8'h10;
    localparam logic [7:0] ADDR_IDENT0 = 8'h14;
    localparam logic [7:0] ADDR_IDENT1 = 8'h18;
    localparam logic [7:0] ADDR_CAPAB0 = 8'h1C;

    // ==========================================================
    // Reset cause bit positions (also interrupt status layout)
    localparam int CAUSE_EXT = 0;
    localparam int CAUSE_POR = 1;
    localparam int CAUSE_BOR = 2;
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_SW = 4;
    localparam int CAUSE_W = 5;

    // Control bits
    localparam int CTRL_BOR_EN = 1;
    localparam int CTRL_WDT_RST_EN = 0;
    localparam int APP_SYSREQ = 2;

    // ==========================================================
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    // Identification values: arbitrary, not those of any real part
    localparam logic [31:0] IDENT0_VAL = 32'h1000_0001;
    localparam logic [31:0] IDENT1_VAL = 32'h2000_0002;
    localparam logic [31:0] CAPAB0_VAL = 32'h0003_0004;

    // ==========================================================
    // Timing: external pin must hold for this many samples
    localparam int PIN_FILTER_CYCLES = 2;
    localparam int BOOT_FETCH_CYCLES = 3;

    typedef enum logic [1:0] {
        BOOT_HOLD = 2'b00,
        BOOT_SP = 2'b01,
        BOOT_PC = 2'b10,
        BOOT_RUN = 2'b11
    } boot_state_type;

endpackage

// *** hdl/reset_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// Async assert, two-flop synchronous release of one reset line
module reset_sync
    import reset_ctrl_pkg::*;
(
    // Clock and combined request
    input wire logic clk_sys_i,
    input wire logic assert_i,
    // Synchronised active-low reset
    output logic rstn_o
);
    logic stage1;
    logic stage2;

    // ==========================================================
    // Assertion is async so a request bites even without a clock
    always_ff @(posedge clk_sys_i or posedge assert_i) begin
        if (assert_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            stage2 <= stage1;
        end
    end

    assign rstn_o = stage2;
endmodule
`default_nettype wire

// *** hdl/pin_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
// Synchronise and debounce the active-low reset pin
module pin_filter
    import reset_ctrl_pkg::*;
#(
    parameter int HOLD = PIN_FILTER_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Raw pin
    input wire logic pin_n_i,
    // Filtered assertion, active high
    output logic active_o
);
    logic sync1;
    logic sync2;
    logic [3:0] run;

    // ==========================================================
    // Two-flop synchroniser; only sync2 feeds logic
    always_ff @(posedge clk_sys_i) begin
        sync1 <= pin_n_i;
        sync2 <= sync1;
    end

    // Count consecutive low samples so a one-cycle glitch is ignored
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            run <= 4'h0;
            active_o <= 1'b0;
        end else if (sync2) begin
            run <= 4'h0;
            active_o <= 1'b0;
        end else begin
            if (run != 4'(HOLD)) run <= run + 4'h1;
            active_o <= (run >= 4'(HOLD - 1));
        end
    end
endmodule
`default_nettype wire

// *** hdl/reset_source_controller.sv ***
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Five reset causes accepted
// - Power-on resets core, test port, peripherals
// - Pin resets core and peripherals, not port
// - Other sources spare test port; soft peripheral
// - System request bit triggers system reset
// - Cause flag set for each reset
// - Cause flags sticky across later resets
// - Power-on clears others, sets its flag
// - Hold reset until power-on detector inactive
// - Boot fetches stack, counter, then runs
// - Power-on asserts only at first power-up
// - Read-only identification registers
// - Brown-out resets only when enabled
// - Peripheral reset on set-then-clear bit
// - Watchdog reset needs second timeout, enable
module reset_source_controller
    import reset_ctrl_pkg::*;
#(
    parameter int PERIPH_N = 8
) (
    // Clock and bus-domain reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Reset sources
    input wire logic por_active_i,
    input wire logic ext_reset_n_i,
    input wire logic brownout_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_int_pending_i,
    // Test-mode pins, must be tied low
    input wire logic test_mode_pin_lo_i,
    input wire logic test_mode_pin_hi_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Reset outputs, active low
    output logic core_rstn_o,
    output logic tap_rstn_o,
    output logic [PERIPH_N-1:0] periph_rstn_o,
    // Boot sequencing and status
    output boot_state_type boot_state_o,
    output logic fetch_sp_o,
    output logic fetch_pc_o,
    output logic test_mode_bad_o,
    output logic irq_o
);
    // Of these flops, only cause and cause_pend are reset by power-on alone
    logic por_q1;
    logic por_q2;
    logic ext_active;
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] irq_mask;
    logic [1:0] ctrl;
    logic [PERIPH_N-1:0] periph_bits;
    logic [PERIPH_N-1:0] periph_pulse;
    logic sys_req;
    logic wdt_armed;
    logic wdt_req;
    logic [CAUSE_W-1:0] cause_pend;
    boot_state_type boot_state;
    logic core_rstn_s;
    logic tm1;
    logic tm2;

    // ==========================================================
    // Source qualification
    wire bor_req = brownout_i & ctrl[CTRL_BOR_EN];
    wire core_req = por_active_i | ext_active | bor_req | sys_req
        | wdt_req;
    wire tap_req = por_active_i;
    wire [CAUSE_W-1:0] cause_now = {sys_req, wdt_req, bor_req,
        por_active_i, ext_active};

    // Bus decode
    wire sel_cause = addr_i == ADDR_CAUSE;
    wire sel_mask = addr_i == ADDR_IRQ_MASK;
    wire sel_ctrl = addr_i == ADDR_CTRL;
    wire sel_periph = addr_i == ADDR_PERIPH_RST;
    wire sel_app = addr_i == ADDR_APP_INT_RST;
    wire sel_id0 = addr_i == ADDR_IDENT0;
    wire sel_id1 = addr_i == ADDR_IDENT1;
    wire sel_cap = addr_i == ADDR_CAPAB0;

    // ==========================================================
    // External pin filter
    pin_filter u_pin (
        .clk_sys_i(clk_sys_i),
        .rstn_i(~por_active_i),
        .pin_n_i(ext_reset_n_i),
        .active_o(ext_active)
    );

    // Reset release synchronisers
    reset_sync u_core (
        .clk_sys_i(clk_sys_i),
        .assert_i(core_req),
        .rstn_o(core_rstn_s)
    );
    reset_sync u_tap (
        .clk_sys_i(clk_sys_i),
        .assert_i(tap_req),
        .rstn_o(tap_rstn_o)
    );

    genvar g;
    generate
        for (g = 0; g < PERIPH_N; g++) begin : g_per
            reset_sync u_per (
                .clk_sys_i(clk_sys_i),
                .assert_i(core_req | periph_pulse[g]),
                .rstn_o(periph_rstn_o[g])
            );
        end
    endgenerate

    assign core_rstn_o = core_rstn_s;

    // ==========================================================
    // Cause register: power-on wipes others and sets its own flag
    always_ff @(posedge clk_sys_i) begin
        if (por_active_i) begin
            cause <= 5'h02;
        end else begin
            cause <= cause | cause_now;
        end
    end

    // Interrupt status: set wins over write-one clear
    always_ff @(posedge clk_sys_i) begin
        if (por_active_i) begin
            cause_pend <= 5'h00;
        end else if (wr_i && sel_cause) begin
            cause_pend <= (cause_pend & ~wdata_i[CAUSE_W-1:0])
                | cause_now;
        end else begin
            cause_pend <= cause_pend | cause_now;
        end
    end

    assign irq_o = |(cause_pend & irq_mask);

    // ==========================================================
    // Control registers live in the always-on domain
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || por_active_i) begin
            irq_mask <= MASK_RESET[CAUSE_W-1:0];
            ctrl <= CTRL_RESET[1:0];
        end else if (wr_i) begin
            if (sel_mask) irq_mask <= wdata_i[CAUSE_W-1:0];
            if (sel_ctrl) ctrl <= wdata_i[1:0];
        end
    end

    // Peripheral bits: reset fires on the falling edge of a bit
    always_ff @(posedge clk_sys_i) begin
        if (!core_rstn_s) begin
            periph_bits <= '0;
            periph_pulse <= '0;
        end else if (wr_i && sel_periph) begin
            periph_bits <= wdata_i[PERIPH_N-1:0];
            periph_pulse <= periph_bits & ~wdata_i[PERIPH_N-1:0];
        end else begin
            periph_pulse <= '0;
        end
    end

    // System request: one write pulls the core into reset
    always_ff @(posedge clk_sys_i) begin
        if (!core_rstn_s) begin
            sys_req <= 1'b0;
        end else if (wr_i && sel_app && wdata_i[APP_SYSREQ]) begin
            sys_req <= 1'b1;
        end
    end

    // Watchdog: first timeout arms, second with interrupt pending
    always_ff @(posedge clk_sys_i) begin
        if (!core_rstn_s) begin
            wdt_armed <= 1'b0;
            wdt_req <= 1'b0;
        end else if (wdt_timeout_i) begin
            wdt_armed <= 1'b1;
            wdt_req <= wdt_armed & wdt_int_pending_i
                & ctrl[CTRL_WDT_RST_EN];
        end else if (!wdt_int_pending_i) begin
            wdt_armed <= 1'b0;
        end
    end

    // ==========================================================
    // Boot sequence after core release
    always_ff @(posedge clk_sys_i) begin
        if (!core_rstn_s) begin
            boot_state <= BOOT_HOLD;
        end else begin
            case (boot_state)
                BOOT_HOLD: boot_state <= BOOT_SP;
                BOOT_SP: boot_state <= BOOT_PC;
                BOOT_PC: boot_state <= BOOT_RUN;
                default: boot_state <= BOOT_RUN;
            endcase
        end
    end

    assign boot_state_o = boot_state;
    assign fetch_sp_o = boot_state == BOOT_SP;
    assign fetch_pc_o = boot_state == BOOT_PC;

    // ==========================================================
    // Test-mode pins are off-domain; flag any non-zero pattern
    always_ff @(posedge clk_sys_i) begin
        tm1 <= test_mode_pin_lo_i | test_mode_pin_hi_i;
        tm2 <= tm1;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            test_mode_bad_o <= 1'b0;
        end else begin
            test_mode_bad_o <= tm2;
        end
    end

    // ==========================================================
    // Read port, data one cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            if (sel_cause) rdata_o <= {27'h0, cause};
            else if (sel_mask) rdata_o <= {27'h0, irq_mask};
            else if (sel_ctrl) rdata_o <= {30'h0, ctrl};
            else if (sel_periph) rdata_o <= 32'(periph_bits);
            else if (sel_id0) rdata_o <= IDENT0_VAL;
            else if (sel_id1) rdata_o <= IDENT1_VAL;
            else if (sel_cap) rdata_o <= CAPAB0_VAL;
            else rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// *** verification/reset_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// Board reset circuit, supply monitor and reset requesters
module reset_partner (
    // Clock
    input wire logic clk_sys_i,
    // Reset sources and test-mode pins
    output logic por_o,
    output logic ext_n_o,
    output logic bor_o,
    output logic wdt_to_o,
    output logic wdt_pend_o,
    output logic tm_lo_o,
    output logic tm_hi_o
);
    // Supply ramps once; the detector never comes back afterwards
    initial begin
        por_o = 1'b1;
        ext_n_o = 1'b1;
        bor_o = 1'b0;
        wdt_to_o = 1'b0;
        wdt_pend_o = 1'b0;
        tm_lo_o = 1'b0;
        tm_hi_o = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        por_o <= 1'b0;
    end

    // Pin pulled low n cycles, then back to the pull-up level
    task automatic pin_low(input int n);
        ext_n_o <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        ext_n_o <= 1'b1;
    endtask

    // Supply dip lasting n cycles
    task automatic bor_high(input int n);
        bor_o <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        bor_o <= 1'b0;
    endtask

    // Two time-outs with the first interrupt never serviced
    task automatic wdt_twice();
        wdt_pend_o <= 1'b1;
        repeat (2) begin
            @(posedge clk_sys_i);
            wdt_to_o <= 1'b1;
            @(posedge clk_sys_i);
            wdt_to_o <= 1'b0;
        end
        wdt_pend_o <= 1'b0;
    endtask

    // Deliberate misuse of a test-mode pin, only when asked
    task automatic tm_bad(input int n);
        tm_lo_o <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        tm_lo_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/reset_ctrl_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// Port checker for the reset controller
module reset_ctrl_sva
    import reset_ctrl_pkg::*;
#(
    parameter int PERIPH_N = 8
) (
    // Clock, reset and sources
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic por_active_i,
    input wire logic ext_reset_n_i,
    input wire logic test_mode_pin_lo_i,
    // Register port
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] rdata_o,
    // Outputs under watch
    input wire logic core_rstn_o,
    input wire logic tap_rstn_o,
    input wire logic [PERIPH_N-1:0] periph_rstn_o,
    input wire logic fetch_sp_o,
    input wire logic fetch_pc_o,
    input wire boot_state_type boot_state_o,
    input wire logic test_mode_bad_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    // Reset fan-out per source
    AST_POR_ALL: assert property (por_active_i |->
        !tap_rstn_o && !core_rstn_o && periph_rstn_o == '0)
        else $error("power-on left a reset released");
    AST_TAP_KEPT: assert property (tap_rstn_o && !por_active_i
        ##1 !por_active_i |-> tap_rstn_o)
        else $error("test port reset without power-on");
    AST_PIN: assert property (!ext_reset_n_i [*5] |->
        !core_rstn_o && periph_rstn_o == '0)
        else $error("held pin did not reset core");
    // Filter must swallow a one-cycle dip
    AST_GLITCH: assert property ((core_rstn_o && ext_reset_n_i)
        ##1 !ext_reset_n_i ##1 ext_reset_n_i |=> core_rstn_o [*6])
        else $error("pin glitch reset the core");
    // Release goes through two stages, boot follows in order
    AST_RELEASE: assert property ($rose(core_rstn_o) |->
        !$past(por_active_i) && !$past(por_active_i, 2))
        else $error("core released too early");
    AST_BOOT: assert property (disable iff (!rstn_i || por_active_i)
        $rose(core_rstn_o) |-> ##[0:3] fetch_sp_o ##1 fetch_pc_o
        ##1 boot_state_o == BOOT_RUN) else $error("boot order wrong");
    // Register side
    AST_IDENT: assert property ($past(rd_i && addr_i == ADDR_IDENT0)
        |-> rdata_o == IDENT0_VAL) else $error("ident word wrong");
    AST_IRQ_MASKED: assert property ($past(wr_i &&
        addr_i == ADDR_IRQ_MASK && wdata_i == 32'h0) |-> !irq_o)
        else $error("masked interrupt still high");
    AST_TEST_PIN: assert property (test_mode_pin_lo_i [*5]
        |-> test_mode_bad_o) else $error("test pin misuse not flagged");

    // Main scenarios reached
    cover property ($rose(core_rstn_o));
    cover property (!irq_o ##1 irq_o);
    cover property (core_rstn_o && periph_rstn_o != '1);
endmodule

bind reset_source_controller reset_ctrl_sva #(.PERIPH_N(PERIPH_N))
    reset_ctrl_sva_inst (.clk_sys_i, .rstn_i, .por_active_i,
    .ext_reset_n_i, .test_mode_pin_lo_i, .rd_i, .wr_i, .addr_i, .wdata_i,
    .rdata_o, .core_rstn_o, .tap_rstn_o, .periph_rstn_o, .fetch_sp_o,
    .fetch_pc_o, .boot_state_o, .test_mode_bad_o, .irq_o);
`default_nettype wire

// *** verification/tb_reset_source_controller.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// Self-checking bench for the reset controller
module tb_reset_source_controller
    import reset_ctrl_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic por, ext_n, bor, wdt_to, wdt_pend, tm_lo, tm_hi;
    logic [31:0] rdata_o;
    logic core_rstn_o, tap_rstn_o, fetch_sp_o, fetch_pc_o;
    logic test_mode_bad_o, irq_o;
    logic [7:0] periph_rstn_o;
    logic [7:0] seen_p = 8'h00;
    boot_state_type boot_state_o;
    int failures = 0, checks = 0, falls = 0;
    int exp_f, cause_m, stat_m, mask_m, r;
    logic [7:0] ids[3] = '{ADDR_IDENT0, ADDR_IDENT1, ADDR_CAPAB0};
    logic [31:0] vals[3] = '{IDENT0_VAL, IDENT1_VAL, CAPAB0_VAL};

    // 20 MHz clock; core resets and peripheral pulses are logged
    always #25 clk_sys_i = ~clk_sys_i;
    always @(negedge core_rstn_o) falls++;
    always @(posedge clk_sys_i) begin
        if (core_rstn_o === 1'b1) seen_p <= seen_p | ~periph_rstn_o;
    end

    reset_partner reset_partner_inst (.clk_sys_i, .por_o(por),
        .ext_n_o(ext_n), .bor_o(bor), .wdt_to_o(wdt_to),
        .wdt_pend_o(wdt_pend), .tm_lo_o(tm_lo), .tm_hi_o(tm_hi));
    reset_source_controller #(.PERIPH_N(8)) reset_source_controller_inst (
        .clk_sys_i, .rstn_i, .por_active_i(por), .ext_reset_n_i(ext_n),
        .brownout_i(bor), .wdt_timeout_i(wdt_to),
        .wdt_int_pending_i(wdt_pend), .test_mode_pin_lo_i(tm_lo),
        .test_mode_pin_hi_i(tm_hi), .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .core_rstn_o, .tap_rstn_o, .periph_rstn_o,
        .boot_state_o, .fetch_sp_o, .fetch_pc_o, .test_mode_bad_o, .irq_o);

    // ====
    // Shared tasks
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // A gap follows each strobe so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rdck(input logic [7:0] a, input logic [31:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", e, rdata_o);
        @(posedge clk_sys_i);
    endtask
    // Let an event play out, update the model, compare boot state, falls, irq and cause
    task automatic ev(input int b, input bit hit);
        int i;
        for (i = 0; hit && i < 40 && core_rstn_o !== 1'b0; i++)
            @(posedge clk_sys_i);
        for (i = 0; i < 20 || (hit && i < 80 && boot_state_o !== BOOT_RUN);
             i++)
            @(posedge clk_sys_i);
        if (hit) begin
            cause_m |= 1 << b;
            stat_m |= 1 << b;
            exp_f++;
        end
        chk("boot", BOOT_RUN, boot_state_o);
        chk("falls", exp_f, falls);
        chk("irq", |(stat_m & mask_m), irq_o);
        rdck(ADDR_CAUSE, cause_m);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ====
    // Main sequence
    initial begin
        void'($urandom(37));
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        for (r = 0; r < 60 && boot_state_o !== BOOT_RUN; r++)
            @(posedge clk_sys_i);
        exp_f = falls;
        cause_m = 1 << CAUSE_POR;
        rdck(ADDR_CAUSE, cause_m);
        chk("tap", 1, tap_rstn_o);
        foreach (ids[k]) begin
            wr(ids[k], $urandom());
            rdck(ids[k], vals[k]);
        end
        rdck(8'h20, 32'h0);
        wr(ADDR_CAUSE, 32'h1F);
        wr(ADDR_IRQ_MASK, 32'h1F);
        stat_m = 0;
        mask_m = 32'h1F;
        reset_partner_inst.pin_low(1);
        ev(CAUSE_EXT, 0);
        reset_partner_inst.pin_low(8);
        ev(CAUSE_EXT, 1);
        wr(ADDR_APP_INT_RST, 1 << APP_SYSREQ);
        ev(CAUSE_SW, 1);
        for (r = 0; r < 2; r++) begin
            wr(ADDR_CTRL, r ? 32'h3 : 32'h0);
            reset_partner_inst.bor_high(10);
            ev(CAUSE_BOR, r[0]);
            reset_partner_inst.wdt_twice();
            ev(CAUSE_WDT, r[0]);
        end
        r = $urandom_range(255, 1);
        seen_p = 8'h00;
        wr(ADDR_PERIPH_RST, 32'(r));
        wr(ADDR_PERIPH_RST, 32'h0);
        repeat (6) @(posedge clk_sys_i);
        chk("periph", 32'(r), 32'(seen_p));
        ev(CAUSE_SW, 0);
        // Clearing status must leave the sticky cause flags alone
        wr(ADDR_CAUSE, 32'h1F);
        stat_m = 0;
        ev(CAUSE_SW, 0);
        wr(ADDR_IRQ_MASK, 32'h0);
        reset_partner_inst.tm_bad(6);
        #1;
        chk("test_pin", 1, test_mode_bad_o);
        print_verdict();
    end

    // Hang guard, well past the few hundred cycles the tests need
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
